// ### rtl/lcdca_display_access.sv
// Frame clock generation, display data access and segment enables
module lcdca_display_access #(
    parameter int SYS_LOG = lcdca_pkg::SYS_PRESCALE_LOG,
    parameter int LOW_LOG = lcdca_pkg::LOW_PRESCALE_LOG
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input wire lcdca_pkg::lcdca_bus_s busReq,
    output logic [7:0] rdData_ff,
    // Low-speed clock ticks and core power state
    input wire logic crystalTick,
    input wire logic intOscTick,
    input wire logic powerDown,
    // Settings held by the control register
    input wire logic displayDriverEnable,
    input wire logic [1:0] dutySel,
    // Shared I/O port data
    input wire logic [31:0] ioPinData,
    output logic [31:0] ioReadData_ff,
    // Driver side
    output logic frameTick_ff,
    output logic [2:0] comIndex_ff,
    output logic comActive_ff,
    output logic [31:0] segmentOutputEnable_ff,
    output logic [31:0] segPixel_ff
);
    localparam int PW = lcdca_pkg::PIXEL_W;
    localparam int NSEG = lcdca_pkg::SEGMENTS;
    localparam int GW = lcdca_pkg::ENABLE_GROUP_W;

    // Counters must fit the prescalers
    if (SYS_LOG < 1 || SYS_LOG > 16 || LOW_LOG < 1 || LOW_LOG > 16)
    begin : g_bad_prescale
        $error("prescaler exponent out of range");
    end
    // Pointer must reach every register; enables come in four bytes
    if ((1 << lcdca_pkg::POINTER_W) != NSEG || NSEG != 4 * GW)
    begin : g_bad_layout
        $error("display register layout mismatch");
    end

    logic [1:0] frameClockSourceSel_ff;
    logic [2:0] frameClockDivider_ff;
    logic [4:0] displayDataPointer_ff;
    logic [NSEG-1:0] segEnable_ff;
    logic [PW-1:0] pixelMem [NSEG];
    logic [SYS_LOG-1:0] sysPre_ff;
    logic [LOW_LOG-1:0] lowPre_ff;
    logic srcTick_ff;
    logic [4:0] postDiv_ff;
    logic [4:0] divMask;
    logic divTick;
    logic [2:0] comCount;
    logic [NSEG-1:0] nxt_segOe;
    lcdca_pkg::lcdca_scan_e scan_ff;

    // Writes to the clock control fields
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            frameClockSourceSel_ff <= lcdca_pkg::SRC_SYSTEM; // R12
            frameClockDivider_ff <= '0; // R12
        end
        else if (busReq.wrStb &&
                 busReq.addr == lcdca_pkg::CLOCK_CONTROL_ADDR)
        begin
            frameClockSourceSel_ff <= busReq.wrData[
                lcdca_pkg::SOURCE_LSB +: lcdca_pkg::SOURCE_W]; // R1
            frameClockDivider_ff <= busReq.wrData[
                lcdca_pkg::DIVIDER_LSB +: lcdca_pkg::DIVIDER_W]; // R2
        end
    end

    // Pointer register
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            displayDataPointer_ff <= '0; // R12
        end
        else if (busReq.wrStb &&
                 busReq.addr == lcdca_pkg::DATA_POINTER_ADDR)
        begin
            displayDataPointer_ff <=
                busReq.wrData[lcdca_pkg::POINTER_W-1:0]; // R6
        end
    end

    // Segment enables, one byte per register
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            segEnable_ff <= '0; // R12
        end
        else if (busReq.wrStb)
        begin
            case (busReq.addr)
                lcdca_pkg::SEG_EN_LOW_ADDR:
                    segEnable_ff[0*GW +: GW] <= busReq.wrData; // R10
                lcdca_pkg::SEG_EN_SECOND_ADDR:
                    segEnable_ff[1*GW +: GW] <= busReq.wrData; // R10
                lcdca_pkg::SEG_EN_THIRD_ADDR:
                    segEnable_ff[2*GW +: GW] <= busReq.wrData; // R10
                lcdca_pkg::SEG_EN_HIGH_ADDR:
                    segEnable_ff[3*GW +: GW] <= busReq.wrData; // R10
                default:
                    segEnable_ff <= segEnable_ff;
            endcase
        end
    end

    // Display memory; a write lands where the pointer stands
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            for (int i = 0; i < NSEG; i++)
            begin
                pixelMem[i] <= '0; // R12
            end
        end
        else if (busReq.wrStb &&
                 busReq.addr == lcdca_pkg::DATA_PORT_ADDR)
        begin
            pixelMem[displayDataPointer_ff] <= busReq.wrData[PW-1:0]; // R8 R7
        end
    end

    // Read data, valid the cycle after the strobe only
    // Reserved positions are padded with zeros, never stored
    always_ff @(posedge clock)
    begin
        if (reset || !busReq.rdStb)
        begin
            rdData_ff <= lcdca_pkg::READ_ZERO;
        end
        else
        begin
            case (busReq.addr)
                lcdca_pkg::SEG_EN_LOW_ADDR:
                    rdData_ff <= segEnable_ff[0*GW +: GW];
                lcdca_pkg::SEG_EN_SECOND_ADDR:
                    rdData_ff <= segEnable_ff[1*GW +: GW];
                lcdca_pkg::SEG_EN_THIRD_ADDR:
                    rdData_ff <= segEnable_ff[2*GW +: GW];
                lcdca_pkg::SEG_EN_HIGH_ADDR:
                    rdData_ff <= segEnable_ff[3*GW +: GW];
                lcdca_pkg::CLOCK_CONTROL_ADDR:
                    rdData_ff <= {2'h0, frameClockSourceSel_ff, 1'b0,
                                  frameClockDivider_ff};
                lcdca_pkg::DATA_POINTER_ADDR:
                    rdData_ff <= {3'h0, displayDataPointer_ff};
                lcdca_pkg::DATA_PORT_ADDR:
                    rdData_ff <= {2'h0, pixelMem[displayDataPointer_ff]}; // R6
                default:
                    rdData_ff <= lcdca_pkg::READ_ZERO; // Unmapped reads zero
            endcase
        end
    end

    // Prescalers; system path stops in power-down, low-speed ones run on
    // Crystal and oscillator share one count; a source swap may
    // shorten the first frame but never stretches it
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            sysPre_ff <= '0;
            lowPre_ff <= '0;
            srcTick_ff <= 1'b0;
        end
        else
        begin
            srcTick_ff <= 1'b0;
            case (frameClockSourceSel_ff)
                lcdca_pkg::SRC_SYSTEM:
                begin
                    if (!powerDown) // R3
                    begin
                        sysPre_ff <= sysPre_ff + 1'b1; // R1
                        srcTick_ff <= &sysPre_ff;
                    end
                end
                lcdca_pkg::SRC_CRYSTAL:
                begin
                    if (crystalTick) // R3 R4
                    begin
                        lowPre_ff <= lowPre_ff + 1'b1; // R1
                        srcTick_ff <= &lowPre_ff;
                    end
                end
                lcdca_pkg::SRC_INT_OSC:
                begin
                    if (intOscTick) // R3
                    begin
                        lowPre_ff <= lowPre_ff + 1'b1; // R1
                        srcTick_ff <= &lowPre_ff;
                    end
                end
                default:
                    srcTick_ff <= 1'b0; // Reserved source gives no clock
            endcase
        end
    end

    // Divider mask from code; reserved codes stop the frame clock
    always_comb
    begin
        divMask = 5'h00;
        divTick = 1'b0;
        if (frameClockDivider_ff <= lcdca_pkg::DIV_MAX_CODE)
        begin
            divMask = 5'(({1'b0, 5'h01} << frameClockDivider_ff) - 6'h01);
            divTick = srcTick_ff && ((postDiv_ff & divMask) == divMask); // R2
        end
    end

    // Post divider counter, powers of two up to 32
    // Runs free, so the first period after a divider change can be short, never long
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            postDiv_ff <= '0;
        end
        else if (srcTick_ff)
        begin
            postDiv_ff <= postDiv_ff + 1'b1; // R2
        end
    end

    // Number of commons scanned for the duty in use
    always_comb
    begin
        case (dutySel)
            lcdca_pkg::DUTY_THIRD:
                comCount = lcdca_pkg::COMS_THIRD;
            lcdca_pkg::DUTY_SIXTH:
                comCount = lcdca_pkg::COMS_SIXTH;
            default:
                comCount = lcdca_pkg::COMS_QUARTER;
        endcase
    end

    // Scan state follows the global enable
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            scan_ff <= lcdca_pkg::SCAN_IDLE;
        end
        else
        begin
            case (scan_ff)
                lcdca_pkg::SCAN_IDLE:
                    if (displayDriverEnable)
                    begin
                        scan_ff <= lcdca_pkg::SCAN_RUN; // R13
                    end
                lcdca_pkg::SCAN_RUN:
                    if (!displayDriverEnable)
                    begin
                        scan_ff <= lcdca_pkg::SCAN_IDLE; // R13
                    end
                default:
                    scan_ff <= lcdca_pkg::SCAN_IDLE;
            endcase
        end
    end

    // Common stepping and pixel transfer on each frame tick
    // Enable gates the outputs at once, not after the state steps
    always_ff @(posedge clock)
    begin
        if (reset || scan_ff != lcdca_pkg::SCAN_RUN ||
            !displayDriverEnable)
        begin
            frameTick_ff <= 1'b0;
            comIndex_ff <= '0;
            comActive_ff <= 1'b0; // R13
            segPixel_ff <= '0;
        end
        else
        begin
            frameTick_ff <= divTick;
            comActive_ff <= 1'b1; // R13
            if (divTick)
            begin
                // Snapshot keeps a mid-frame write from tearing a column
                for (int s = 0; s < NSEG; s++)
                begin
                    segPixel_ff[s] <= pixelMem[s][comIndex_ff]; // R15 R9
                end
                if (comIndex_ff >= comCount - 3'h1)
                begin
                    comIndex_ff <= '0;
                end
                else
                begin
                    comIndex_ff <= comIndex_ff + 3'h1;
                end
            end
        end
    end

    // Effective segment enables after gating and pin sharing
    always_comb
    begin
        nxt_segOe = displayDriverEnable ? segEnable_ff : '0; // R13
        if (dutySel == lcdca_pkg::DUTY_SIXTH)
        begin
            nxt_segOe[lcdca_pkg::COM4_SEG] = 1'b0; // R14
            nxt_segOe[lcdca_pkg::COM5_SEG] = 1'b0; // R14
        end
        if (frameClockSourceSel_ff == lcdca_pkg::SRC_CRYSTAL)
        begin
            nxt_segOe[lcdca_pkg::CRYSTAL_IN_SEG] = 1'b0; // R5
            nxt_segOe[lcdca_pkg::CRYSTAL_OUT_SEG] = 1'b0; // R5
        end
    end

    // Registered enables and masked port reads
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            segmentOutputEnable_ff <= '0;
            ioReadData_ff <= '0;
        end
        else
        begin
            segmentOutputEnable_ff <= nxt_segOe;
            // Enable bits gated by the global enable, not by pin sharing, mask reads; port latch writes are untouched
            ioReadData_ff <= ioPinData &
                ~(segEnable_ff & {NSEG{displayDriverEnable}}); // R11
        end
    end
endmodule

// ### rtl/lcdca_pkg.sv
// Constants and types of the segment display clock and data access block
// How it works
// (R1) Source field picks system, crystal or oscillator clock
// (R2) Divider field divides selected clock by 1..32
// (R3) Low-speed sources keep display running in power-down
// (R4) Software starts crystal before selecting it
// (R5) Crystal source removes segments 29 and 30
// (R6) Five-bit pointer selects the display register
// (R7) Software loads pointer before data port access
// (R8) Data port write stores into pointed register
// (R9) Data bit one darkens, zero clears pixel
// (R10) Four registers hold 32 segment enable bits
// (R11) Enabled segment reads port data bit as zero
// (R12) All registers reset to zero
// (R13) Global enable gates common and segment outputs
// (R14) Sixth duty ignores enables of segments 0, 1
// (R15) Pixel data moves to drivers on frame clock
package lcdca_pkg;
    // Register byte addresses
    localparam logic [7:0] SEG_EN_LOW_ADDR = 8'hE5;
    localparam logic [7:0] SEG_EN_SECOND_ADDR = 8'hE6;
    localparam logic [7:0] SEG_EN_THIRD_ADDR = 8'hE7;
    localparam logic [7:0] SEG_EN_HIGH_ADDR = 8'hEE;
    localparam logic [7:0] CLOCK_CONTROL_ADDR = 8'hFA;
    localparam logic [7:0] DATA_POINTER_ADDR = 8'hFB;
    localparam logic [7:0] DATA_PORT_ADDR = 8'hFC;
    // Field positions and widths
    localparam int SOURCE_LSB = 4;
    localparam int SOURCE_W = 2;
    localparam int DIVIDER_LSB = 0;
    localparam int DIVIDER_W = 3;
    localparam int POINTER_W = 5;
    localparam int PIXEL_W = 6;
    localparam int SEGMENTS = 32;
    localparam int ENABLE_GROUP_W = 8;
    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // Clock source codes
    localparam logic [1:0] SRC_SYSTEM = 2'h0;
    localparam logic [1:0] SRC_CRYSTAL = 2'h1;
    localparam logic [1:0] SRC_INT_OSC = 2'h2;
    // Highest legal divider code, 1/32
    localparam logic [2:0] DIV_MAX_CODE = 3'h5;
    // Prescaler exponents
    localparam int SYS_PRESCALE_LOG = 12;
    localparam int LOW_PRESCALE_LOG = 4;
    // Pins lost to the crystal, pins turned into commons by sixth duty
    localparam int CRYSTAL_IN_SEG = 29;
    localparam int CRYSTAL_OUT_SEG = 30;
    localparam int COM4_SEG = 0;
    localparam int COM5_SEG = 1;
    // Duty codes and common counts
    localparam logic [1:0] DUTY_QUARTER = 2'h0;
    localparam logic [1:0] DUTY_THIRD = 2'h1;
    localparam logic [1:0] DUTY_SIXTH = 2'h2;
    localparam logic [2:0] COMS_QUARTER = 3'h4;
    localparam logic [2:0] COMS_THIRD = 3'h3;
    localparam logic [2:0] COMS_SIXTH = 3'h6;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic wrStb;
        logic rdStb;
    } lcdca_bus_s;

    // Scan state, one-hot
    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b01,
        SCAN_RUN = 2'b10
    } lcdca_scan_e;
endpackage

// ### testbench/lcdca_display_access_props.sv
// Port assertions of the display access block
module lcdca_display_access_props (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input wire lcdca_pkg::lcdca_bus_s busReq,
    input wire logic [7:0] rdData_ff,
    // Settings and port data
    input wire logic displayDriverEnable,
    input wire logic [1:0] dutySel,
    input wire logic [31:0] ioPinData,
    input wire logic [31:0] ioReadData_ff,
    // Driver side
    input wire logic frameTick_ff,
    input wire logic [2:0] comIndex_ff,
    input wire logic comActive_ff,
    input wire logic [31:0] segmentOutputEnable_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    // Read data stands only in the cycle after a read
    rd_idle_zero_a: assert property (
        !$past(busReq.rdStb) |-> rdData_ff == 8'h00) else $error("stray data");
    unmapped_read_a: assert property (
        busReq.rdStb && !(busReq.addr inside {8'hE5, 8'hE6, 8'hE7, 8'hEE,
        8'hFA, 8'hFB, 8'hFC}) |=> rdData_ff == 8'h00) else $error("unmapped");
    clock_rsvd_a: assert property (
        busReq.rdStb && busReq.addr == 8'hFA |=> (rdData_ff & 8'hC8) == 8'h00)
        else $error("clock reserved bits");
    pointer_rsvd_a: assert property (
        busReq.rdStb && busReq.addr == 8'hFB |=> rdData_ff[7:5] == 3'h0)
        else $error("pointer reserved bits");
    data_rsvd_a: assert property (
        busReq.rdStb && busReq.addr == 8'hFC |=> rdData_ff[7:6] == 2'h0)
        else $error("data reserved bits");
    // Frame tick is a single-cycle pulse
    tick_single_a: assert property (
        frameTick_ff |=> !frameTick_ff) else $error("long tick");
    off_quiet_a: assert property (
        !displayDriverEnable && !$past(displayDriverEnable) |-> !comActive_ff
        && !frameTick_ff && segmentOutputEnable_ff == 32'h0)
        else $error("driver active while off");
    // A bit may only read high where the pin was high, never elsewhere
    io_clear_a: assert property (
        (ioReadData_ff & ~$past(ioPinData)) == 32'h0) else $error("io high");
    io_pass_a: assert property (
        !$past(reset) && !$past(displayDriverEnable) |->
        ioReadData_ff == $past(ioPinData)) else $error("io masked while off");
    com_step_a: assert property (
        frameTick_ff && $past(dutySel) == 2'h0 && $past(comIndex_ff) < 3'h4
        |-> comIndex_ff == (($past(comIndex_ff) + 3'h1) & 3'h3))
        else $error("common step");
    sixth_trim_a: assert property (
        dutySel == 2'h2 && $past(dutySel) == 2'h2
        |-> segmentOutputEnable_ff[1:0] == 2'h0) else $error("sixth duty");
    // Main scenarios reached
    cover property (frameTick_ff);
    cover property (busReq.rdStb && busReq.addr == 8'hFC);
    cover property (dutySel == 2'h2 && segmentOutputEnable_ff != 32'h0);
endmodule

// ### testbench/lcdca_panel_model.sv
// Behavioural segment glass panel watching the driver side
module lcdca_panel_model (
    // Clock
    input wire logic clock,
    // Driver side
    input wire logic frameTick_ff,
    input wire logic [2:0] comIndex_ff,
    input wire logic [31:0] segmentOutputEnable_ff,
    input wire logic [31:0] segPixel_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] image [8];
    logic [2:0] lastCom = 3'h0;
    int tickCount = 0;

    // Column latched against the common scanned before the step
    always @(posedge clock)
    begin
        lastCom <= comIndex_ff;
        if (frameTick_ff)
        begin
            tickCount <= tickCount + 1;
            // Undriven segments stay clear
            image[lastCom] <= segPixel_ff & segmentOutputEnable_ff;
        end
    end
endmodule

// ### testbench/lcd_clock_and_display_data_access_tb_top.sv
// Self-checking bench of the display access block
`define CHK(a, e) \
    begin \
        samplesChecked++; \
        if ((a) !== (e)) \
        begin \
            badCount++; \
            $display("ERROR t=%0t got %h exp %h", $time, a, e); \
        end \
    end
module lcd_clock_and_display_data_access_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ADDRS [8] = '{8'hE5, 8'hE6, 8'hE7, 8'hEE,
        8'hFA, 8'hFB, 8'hFC, 8'h00};
    logic clock = 1'b0;
    logic reset = 1'b1;
    lcdca_pkg::lcdca_bus_s busReq = '0;
    logic crystalTick = 1'b0;
    logic intOscTick = 1'b0;
    logic powerDown = 1'b0;
    logic displayDriverEnable = 1'b0;
    logic [1:0] dutySel = 2'h0;
    logic [31:0] ioPinData = 32'h0;
    logic [31:0] segEn = 32'h6A5C_F00F;
    logic [31:0] expCol;
    logic [5:0] mem [32];
    wire logic [7:0] rdData_ff;
    wire logic [31:0] ioReadData_ff;
    wire logic [31:0] segOe;
    wire logic [31:0] segPixel;
    wire logic [2:0] comIndex;
    wire logic frameTick_ff;
    wire logic comActive;
    int badCount = 0;
    int samplesChecked = 0;
    int ph = 0;
    int n;

    always #2.5 clock = ~clock;
    // Low-speed sources run from the start, crystal already on
    always @(posedge clock)
    begin
        ph <= ph + 1;
        crystalTick <= (ph % 4 == 0);
        intOscTick <= (ph % 3 == 0);
    end

    lcdca_display_access #(.SYS_LOG(4), .LOW_LOG(4)) u_dut (
        .clock(clock), .reset(reset), .busReq(busReq), .rdData_ff(rdData_ff),
        .crystalTick(crystalTick), .intOscTick(intOscTick),
        .powerDown(powerDown), .displayDriverEnable(displayDriverEnable),
        .dutySel(dutySel), .ioPinData(ioPinData),
        .ioReadData_ff(ioReadData_ff), .frameTick_ff(frameTick_ff),
        .comIndex_ff(comIndex), .comActive_ff(comActive),
        .segmentOutputEnable_ff(segOe), .segPixel_ff(segPixel));
    lcdca_panel_model u_panel (.clock(clock), .frameTick_ff(frameTick_ff),
        .comIndex_ff(comIndex), .segmentOutputEnable_ff(segOe),
        .segPixel_ff(segPixel));

    // One write strobe, then an idle cycle so strobes never merge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        busReq <= '0;
        @(posedge clock);
    endtask
    // Read data is looked at in the one cycle it stands
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        busReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        busReq.rdStb <= 1'b0;
        #1;
        `CHK(rdData_ff, e)
        @(posedge clock);
    endtask
    // First two intervals may be partial after a settings change
    task automatic per(input int e);
        repeat (3)
        begin
            n = 0;
            do
            begin
                @(posedge clock);
                #1;
                n++;
            end while (frameTick_ff !== 1'b1 && n < 4000);
        end
        `CHK(n, e)
        @(posedge clock);
    endtask
    task automatic noTick();
        n = u_panel.tickCount;
        repeat (1500) @(posedge clock);
        `CHK(u_panel.tickCount - n, 0)
    endtask
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Tests
    initial
    begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        foreach (ADDRS[i]) rd(ADDRS[i], 8'h00);
        $display("reset values done");
        wr(8'hFA, 8'hFF);
        rd(8'hFA, 8'h37);
        wr(8'hFB, 8'hFF);
        rd(8'hFB, 8'h1F);
        for (int s = 0; s < 32; s++)
        begin
            mem[s] = 6'(s * 7 + 5);
            wr(8'hFB, 8'(s));
            wr(8'hFC, {2'h3, mem[s]});
        end
        for (int s = 31; s >= 0; s -= 5)
        begin
            wr(8'hFB, 8'(s));
            rd(8'hFC, {2'h0, mem[s]});
        end
        for (int k = 0; k < 4; k++)
        begin
            wr(ADDRS[k], segEn[8 * k +: 8]);
            rd(ADDRS[k], segEn[8 * k +: 8]);
        end
        $display("register access done");
        ioPinData <= 32'hFFFF_FFFF;
        wr(8'hFA, 8'h00);
        settle();
        `CHK(ioReadData_ff, 32'hFFFF_FFFF)
        @(posedge clock);
        displayDriverEnable <= 1'b1;
        settle();
        `CHK(ioReadData_ff, ~segEn)
        `CHK(segOe, segEn)
        `CHK(comActive, 1'b1)
        @(posedge clock);
        wr(8'hFA, 8'h10);
        settle();
        `CHK(segOe, segEn & ~32'h6000_0000)
        @(posedge clock);
        dutySel <= 2'h2;
        settle();
        `CHK(segOe, segEn & ~32'h6000_0003)
        @(posedge clock);
        dutySel <= 2'h0;
        $display("segment enables done");
        for (int d = 0; d <= 5; d++)
        begin
            wr(8'hFA, 8'(d));
            per(16 << d);
        end
        wr(8'hFA, 8'h11);
        per(128);
        wr(8'hFA, 8'h20);
        per(48);
        powerDown <= 1'b1;
        per(48);
        wr(8'hFA, 8'h10);
        per(64);
        wr(8'hFA, 8'h00);
        noTick();
        powerDown <= 1'b0;
        wr(8'hFA, 8'h30);
        noTick();
        wr(8'hFA, 8'h06);
        noTick();
        $display("frame clock done");
        wr(8'hFA, 8'h00);
        repeat (2) per(16);
        for (int c = 0; c < 4; c++)
        begin
            foreach (mem[s]) expCol[s] = mem[s][c] & segEn[s];
            `CHK(u_panel.image[c], expCol)
        end
        $display("pixel scan done");
        // Third duty scans commons 0 to 2 only
        dutySel <= 2'h1;
        repeat (4)
        begin
            per(16);
            #1;
            `CHK(comIndex < 3'h3, 1'b1)
        end
        @(posedge clock);
        dutySel <= 2'h0;
        $display("third duty done");
        // Driver off: outputs quiet, port reads pass through
        displayDriverEnable <= 1'b0;
        settle();
        `CHK(comActive, 1'b0)
        `CHK(segOe, 32'h0)
        `CHK(ioReadData_ff, 32'hFFFF_FFFF)
        noTick();
        $display("driver off done");
        // Second reset in mid-run, driver enabled
        displayDriverEnable <= 1'b1;
        reset <= 1'b1;
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        foreach (ADDRS[i]) rd(ADDRS[i], 8'h00);
        wr(8'hFB, 8'h1F);
        rd(8'hFC, 8'h00);
        settle();
        `CHK(segOe, 32'h0)
        `CHK(ioReadData_ff, 32'hFFFF_FFFF)
        `CHK(comActive, 1'b1)
        $display("mid-run reset done");
        summarize();
    end

    // Whole run needs about 50 us; four times that means a hang
    initial
    begin
        #200us;
        badCount++;
        summarize();
    end
endmodule

bind lcdca_display_access lcdca_display_access_props u_props (
    .clock(clock), .reset(reset), .busReq(busReq), .rdData_ff(rdData_ff),
    .displayDriverEnable(displayDriverEnable), .dutySel(dutySel),
    .ioPinData(ioPinData), .ioReadData_ff(ioReadData_ff),
    .frameTick_ff(frameTick_ff), .comIndex_ff(comIndex_ff),
    .comActive_ff(comActive_ff),
    .segmentOutputEnable_ff(segmentOutputEnable_ff));
